/* logic/radio_packet_link_engine.v */
// Packet engine of a radio transceiver: AHB-Lite register slave, TX/RX FIFOs,
// framing with preamble and CRC, pipe address filtering, auto-ack and retransmission.
// Assumes one 100 MHz clock; the link clock, frame and data pins are asynchronous.
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "link_engine_regs.vh"

module radio_packet_link_engine (
	input  wire        I_CLK,        // System clock, 100 MHz
	input  wire        I_ARST_N,     // Asynchronous reset, active low
	input  wire        I_HSEL,       // AHB slave select
	input  wire [31:0] I_HADDR,      // AHB address
	input  wire [1:0]  I_HTRANS,     // AHB transfer type
	input  wire        I_HWRITE,     // AHB write
	input  wire [2:0]  I_HSIZE,      // AHB size, word only
	input  wire [31:0] I_HWDATA,     // AHB write data
	input  wire        I_HREADY,     // AHB bus ready
	output reg  [31:0] O_HRDATA,     // AHB read data
	output reg         O_HREADYOUT,  // AHB slave ready
	output reg         O_HRESP,      // AHB response, always OKAY
	output reg         O_IRQ,        // Interrupt, active high level
	input  wire        I_LINK_CLK,   // Link bit clock from the air side
	input  wire        I_LINK_FRAME, // Incoming frame envelope
	input  wire        I_LINK_DATA,  // Incoming serial data
	output reg         O_LINK_FRAME, // Outgoing frame envelope
	output reg         O_LINK_DATA   // Outgoing serial data
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_SEND = 3'b010;
	localparam [2:0] ST_WAIT = 3'b100;

	// ================================================================
	// Functions
	function [7:0] crc8;
		input [79:0] d;
		integer      k;
		reg   [7:0]  c;
		reg          fb;
		begin
			c = 8'h00;
			for (k = 79; k >= 0; k = k - 1) begin
				fb = c[7] ^ d[k];
				c = {c[6:0], 1'b0};
				if (fb)
					c = c ^ `CRC_POLY;
			end
			crc8 = c;
		end
	endfunction

	function [95:0] make_frame;
		input [39:0] addr;
		input [7:0]  ctl;
		input [31:0] pay;
		begin
			make_frame = {`PREAMBLE, addr, ctl, pay, crc8({addr, ctl, pay})};
		end
	endfunction

	function [1:0] ptr_inc;
		input [1:0] p;
		begin
			ptr_inc = (p == `FIFO_LAST) ? 2'h0 : p + 2'h1;
		end
	endfunction

	// ================================================================
	// Declarations
	reg  [2:0]  lclk_s;
	reg  [2:0]  frame_s;
	reg  [1:0]  data_s;
	reg  [95:0] rx_sh;
	reg  [6:0]  rx_cnt;
	reg         rx_done;
	reg         pend;
	reg  [7:0]  p_addr;
	reg         p_write;
	reg  [1:0]  cfg;
	reg  [2:0]  mask;
	reg  [3:0]  retry_count_limit;
	reg  [39:0] p0_addr;
	reg  [31:0] shared_hi;
	reg  [7:0]  low_byte [1:5];
	reg  [39:0] tx_addr;
	reg  [2:0]  flags;
	reg  [2:0]  ev;
	reg  [31:0] tx_mem [0:2];
	reg  [1:0]  tx_rd;
	reg  [1:0]  tx_wr;
	reg  [1:0]  tx_num;
	reg         tx_pop;
	reg  [34:0] rx_mem [0:2];
	reg  [1:0]  rx_rd;
	reg  [1:0]  rx_wr;
	reg  [1:0]  rx_num;
	reg         rx_push;
	reg  [34:0] rx_wdata;
	reg  [2:0]  state;
	reg         sending_ack;
	reg  [3:0]  retries;
	reg  [7:0]  wait_cnt;
	reg         start_req;
	reg  [95:0] tx_sh;
	reg  [6:0]  tx_cnt;
	reg  [31:0] rd_mux;
	reg  [2:0]  rx_pipe;
	integer     j;
	integer     pipe_idx;

	wire        lclk_rise  = lclk_s[1] & ~lclk_s[2];
	wire        lclk_fall  = ~lclk_s[1] & lclk_s[2];
	wire        frame_end  = ~frame_s[1] & frame_s[2];
	wire        wr_stb     = pend & p_write;
	wire        rd_stb     = pend & ~p_write;
	wire [39:0] rx_addr    = rx_sh[87:48];
	wire [7:0]  rx_ctl     = rx_sh[47:40];
	wire [31:0] rx_pay     = rx_sh[39:8];
	wire        rx_good    = rx_done & (rx_sh[95:88] == `PREAMBLE) & (crc8(rx_sh[87:8]) == rx_sh[7:0]);
	wire        tx_push    = wr_stb & (p_addr == `REG_TX_DATA) & (tx_num != `FIFO_FULL);
	wire        rx_pop     = rd_stb & (p_addr == `REG_RX_DATA) & (rx_num != 2'h0);
	wire        status_rd  = rd_stb & (p_addr == `REG_STATUS);
	wire        is_prx     = cfg[`CFG_PRX];
	wire        ack_en     = cfg[`CFG_ACK];

	// ================================================================
	// Link input synchronisers and receive shifter
	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			lclk_s  <= 3'h0;
			frame_s <= 3'h0;
			data_s  <= 2'h0;
			rx_sh   <= 96'h0;
			rx_cnt  <= 7'h0;
			rx_done <= 1'b0;
		end else begin
			lclk_s  <= {lclk_s[1], lclk_s[0], I_LINK_CLK};
			frame_s <= {frame_s[1], frame_s[0], I_LINK_FRAME};
			data_s  <= {data_s[0], I_LINK_DATA};
			rx_done <= 1'b0;
			if (frame_end) begin
				rx_done <= (rx_cnt == `FRAME_BITS);
				rx_cnt  <= 7'h0;
			end else if (lclk_rise && frame_s[1]) begin
				rx_sh <= {rx_sh[94:0], data_s[1]};
				if (rx_cnt != 7'h7F)
					rx_cnt <= rx_cnt + 7'h1;
			end
		end
	end

	// ================================================================
	// Pipe address filter
	always @* begin
		rx_pipe  = `PIPE_NONE;
		pipe_idx = 0;
		if (rx_addr[39:8] == shared_hi) begin
			for (pipe_idx = 5; pipe_idx >= 1; pipe_idx = pipe_idx - 1) begin
				if (rx_addr[7:0] == low_byte[pipe_idx])
					rx_pipe = pipe_idx[2:0];
			end
		end
		if (rx_addr == p0_addr)
			rx_pipe = 3'h0;
	end

	// ================================================================
	// AHB-Lite slave: one wait state so read data leaves a flip-flop
	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pend              <= 1'b0;
			p_addr            <= 8'h00;
			p_write           <= 1'b0;
			O_HREADYOUT       <= 1'b1;
			O_HRESP           <= 1'b0;
			O_HRDATA          <= 32'h00000000;
			cfg               <= `RST_CONFIG;
			mask              <= `RST_MASK;
			retry_count_limit <= `RST_LIMIT;
			p0_addr           <= `RST_ADDR;
			shared_hi         <= 32'h00000000;
			tx_addr           <= `RST_ADDR;
			for (j = 1; j <= 5; j = j + 1)
				low_byte[j] <= `RST_BYTE;
		end else begin
			O_HRESP <= 1'b0;
			if (I_HSEL && I_HTRANS[1] && I_HREADY) begin
				pend        <= 1'b1;
				p_addr      <= {I_HADDR[7:2], 2'b00};
				p_write     <= I_HWRITE;
				O_HREADYOUT <= 1'b0;
			end else if (pend) begin
				pend        <= 1'b0;
				O_HREADYOUT <= 1'b1;
				if (!p_write)
					O_HRDATA <= rd_mux;
			end
			if (wr_stb) begin
				case (p_addr)
					`REG_CONFIG:  cfg               <= I_HWDATA[1:0];
					`REG_MASK:    mask              <= I_HWDATA[2:0];
					`REG_RETRY:   retry_count_limit <= I_HWDATA[3:0];
					`REG_P0_LO:   p0_addr[31:0]     <= I_HWDATA;
					`REG_P0_HI:   p0_addr[39:32]    <= I_HWDATA[7:0];
					`REG_SHARED:  shared_hi         <= I_HWDATA;
					`REG_LOW_1_4: begin
						low_byte[1] <= I_HWDATA[7:0];
						low_byte[2] <= I_HWDATA[15:8];
						low_byte[3] <= I_HWDATA[23:16];
						low_byte[4] <= I_HWDATA[31:24];
					end
					`REG_LOW_5:   low_byte[5]       <= I_HWDATA[7:0];
					`REG_TXA_LO:  tx_addr[31:0]     <= I_HWDATA;
					`REG_TXA_HI:  tx_addr[39:32]    <= I_HWDATA[7:0];
					default: ;
				endcase
			end
		end
	end

	// Unmapped and write-only offsets read as zero
	always @* begin
		rd_mux = 32'h00000000;
		case (p_addr)
			`REG_CONFIG:  rd_mux[1:0] = cfg;
			`REG_STATUS: begin
				rd_mux[2:0]                          = flags;
				rd_mux[`STA_PIPE_LSB +: 3]           = (rx_num != 2'h0) ? rx_mem[rx_rd][34:32] : `PIPE_NONE;
				rd_mux[`STA_TX_FULL]                 = (tx_num == `FIFO_FULL);
				rd_mux[`STA_TX_EMPTY]                = (tx_num == 2'h0);
				rd_mux[`STA_RX_EMPTY]                = (rx_num == 2'h0);
			end
			`REG_MASK:    rd_mux[2:0] = mask;
			`REG_RETRY:   rd_mux[7:0] = {retries, retry_count_limit};
			`REG_P0_LO:   rd_mux      = p0_addr[31:0];
			`REG_P0_HI:   rd_mux[7:0] = p0_addr[39:32];
			`REG_SHARED:  rd_mux      = shared_hi;
			`REG_LOW_1_4: rd_mux      = {low_byte[4], low_byte[3], low_byte[2], low_byte[1]};
			`REG_LOW_5:   rd_mux[7:0] = low_byte[5];
			`REG_TXA_LO:  rd_mux      = tx_addr[31:0];
			`REG_TXA_HI:  rd_mux[7:0] = tx_addr[39:32];
			`REG_RX_DATA: rd_mux      = (rx_num != 2'h0) ? rx_mem[rx_rd][31:0] : 32'h00000000;
			default:      rd_mux      = 32'h00000000;
		endcase
	end

	// ================================================================
	// Sticky flags, cleared by a status read; a new event wins over the clear
	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			flags <= 3'h0;
			O_IRQ <= 1'b0;
		end else begin
			flags <= (flags & ~{3{status_rd}}) | ev;
			O_IRQ <= |(flags & mask);
		end
	end

	// ================================================================
	// FIFOs, no power gating so host access never stalls
	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tx_rd  <= 2'h0;
			tx_wr  <= 2'h0;
			tx_num <= 2'h0;
			rx_rd  <= 2'h0;
			rx_wr  <= 2'h0;
			rx_num <= 2'h0;
		end else begin
			if (tx_push) begin
				tx_mem[tx_wr] <= I_HWDATA;
				tx_wr         <= ptr_inc(tx_wr);
			end
			if (tx_pop)
				tx_rd <= ptr_inc(tx_rd);
			if (tx_push && !tx_pop)
				tx_num <= tx_num + 2'h1;
			else if (tx_pop && !tx_push)
				tx_num <= tx_num - 2'h1;
			if (rx_push) begin
				rx_mem[rx_wr] <= rx_wdata;
				rx_wr         <= ptr_inc(rx_wr);
			end
			if (rx_pop)
				rx_rd <= ptr_inc(rx_rd);
			if (rx_push && !rx_pop)
				rx_num <= rx_num + 2'h1;
			else if (rx_pop && !rx_push)
				rx_num <= rx_num - 2'h1;
		end
	end

	// ================================================================
	// Protocol engine: send, wait for ack, retry; answer as receiver
	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state        <= ST_IDLE;
			sending_ack  <= 1'b0;
			retries      <= 4'h0;
			wait_cnt     <= 8'h00;
			start_req    <= 1'b0;
			tx_sh        <= 96'h0;
			tx_cnt       <= 7'h0;
			tx_pop       <= 1'b0;
			rx_push      <= 1'b0;
			rx_wdata     <= 35'h0;
			ev           <= 3'h0;
			O_LINK_FRAME <= 1'b0;
			O_LINK_DATA  <= 1'b0;
		end else begin
			tx_pop  <= 1'b0;
			rx_push <= 1'b0;
			ev      <= 3'h0;
			case (state)
				ST_IDLE: begin
					if (is_prx) begin
						if (rx_good && rx_ctl == `CTL_DATA && rx_pipe != `PIPE_NONE) begin
							// Full FIFO: drop without ack, so the sender retries
							if (rx_num != `FIFO_FULL) begin
								rx_push         <= 1'b1;
								rx_wdata        <= {rx_pipe, rx_pay};
								ev[`FLG_RX]     <= 1'b1;
								if (ack_en) begin
									tx_sh       <= make_frame(rx_addr, `CTL_ACK, 32'h00000000);
									tx_cnt      <= 7'h0;
									sending_ack <= 1'b1;
									state       <= ST_SEND;
								end
							end
						end
					// Let a pending pop land first, or the delivered word goes out again
					end else if (start_req && tx_num != 2'h0 && !tx_pop) begin
						tx_sh       <= make_frame(tx_addr, `CTL_DATA, tx_mem[tx_rd]);
						tx_cnt      <= 7'h0;
						retries     <= 4'h0;
						sending_ack <= 1'b0;
						state       <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (lclk_fall) begin
						if (tx_cnt == `FRAME_BITS) begin
							O_LINK_FRAME <= 1'b0;
							O_LINK_DATA  <= 1'b0;
							if (sending_ack) begin
								state <= ST_IDLE;
							end else if (ack_en) begin
								wait_cnt <= 8'h00;
								state    <= ST_WAIT;
							end else begin
								tx_pop        <= 1'b1;
								ev[`FLG_SENT] <= 1'b1;
								state         <= ST_IDLE;
							end
						end else begin
							O_LINK_FRAME <= 1'b1;
							O_LINK_DATA  <= tx_sh[95];
							tx_sh        <= {tx_sh[94:0], 1'b0};
							tx_cnt       <= tx_cnt + 7'h1;
						end
					end
				end
				ST_WAIT: begin
					// Acks come back on pipe zero, which the host set to the target address
					if (rx_good && rx_ctl == `CTL_ACK && rx_addr == p0_addr) begin
						tx_pop        <= 1'b1;
						ev[`FLG_SENT] <= 1'b1;
						state         <= ST_IDLE;
					end else if (lclk_rise) begin
						if (wait_cnt == `ACK_WAIT_BITS) begin
							if (retries == retry_count_limit) begin
								ev[`FLG_MAXRT] <= 1'b1;
								state          <= ST_IDLE;
							end else begin
								retries <= retries + 4'h1;
								tx_sh   <= make_frame(tx_addr, `CTL_DATA, tx_mem[tx_rd]);
								tx_cnt  <= 7'h0;
								state   <= ST_SEND;
							end
						end else begin
							wait_cnt <= wait_cnt + 8'h01;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
			// A send command arriving with the start still wins
			if (state == ST_IDLE && !is_prx && start_req && tx_num != 2'h0 && !tx_pop)
				start_req <= 1'b0;
			if (wr_stb && p_addr == `REG_CMD && I_HWDATA[`CMD_SEND])
				start_req <= 1'b1;
		end
	end

endmodule // radio_packet_link_engine

/* pkg/link_engine_regs.vh */
// Constants for the radio packet link engine: register map, fields, frame layout.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef LINK_ENGINE_REGS_VH
`define LINK_ENGINE_REGS_VH

// ================================================================
// Register byte offsets (low address byte)
`define REG_CONFIG      8'h00
`define REG_STATUS      8'h04
`define REG_MASK        8'h08
`define REG_RETRY       8'h0C
`define REG_P0_LO       8'h10
`define REG_P0_HI       8'h14
`define REG_SHARED      8'h18
`define REG_LOW_1_4     8'h1C
`define REG_LOW_5       8'h20
`define REG_TXA_LO      8'h24
`define REG_TXA_HI      8'h28
`define REG_TX_DATA     8'h2C
`define REG_RX_DATA     8'h30
`define REG_CMD         8'h34

// ================================================================
// Field positions
`define CFG_PRX         0
`define CFG_ACK         1
`define CMD_SEND        0
`define FLG_RX          0
`define FLG_SENT        1
`define FLG_MAXRT       2
`define STA_PIPE_LSB    4
`define STA_TX_FULL     8
`define STA_TX_EMPTY    9
`define STA_RX_EMPTY    10
`define RTY_COUNT_LSB   4

// ================================================================
// Reset values
`define RST_CONFIG      2'h0
`define RST_MASK        3'h7
`define RST_LIMIT       4'h3
`define RST_ADDR        40'h0000000000
`define RST_BYTE        8'h00

// ================================================================
// Frame and timing
`define FIFO_LAST       2'h2
`define FIFO_FULL       2'h3
`define PREAMBLE        8'hAA
`define CRC_POLY        8'h07
`define CTL_DATA        8'h00
`define CTL_ACK         8'h01
`define FRAME_BITS      7'h60
`define ACK_WAIT_BITS   8'hC8
`define PIPE_NONE       3'h7
`define PIPE_LAST       3'h5

`endif

/* verif/engine_props.sv */
// Concurrent checks on the top ports of the radio packet link engine.
// Assumes one clock domain; bound to the engine by the bind statement at the foot.
`timescale 1ns/1ps
module engine_props (
	input wire        I_CLK,        // Clock
	input wire        I_ARST_N,     // Reset, active low
	input wire        I_HSEL,       // Select
	input wire [31:0] I_HADDR,      // Address
	input wire [1:0]  I_HTRANS,     // Transfer type
	input wire        I_HWRITE,     // Write
	input wire        I_HREADY,     // Bus ready
	input wire [31:0] O_HRDATA,     // Read data
	input wire        O_HREADYOUT,  // Slave ready
	input wire        O_HRESP,      // Response
	input wire        O_IRQ,        // Interrupt
	input wire        I_LINK_FRAME, // Incoming frame
	input wire        O_LINK_FRAME, // Outgoing frame
	input wire        O_LINK_DATA   // Outgoing data
);
	wire        take    = I_HSEL && I_HTRANS[1] && I_HREADY;
	wire        rd_stat = take && !I_HWRITE && I_HADDR[7:2] == 6'h01;
	logic [9:0] flen;

	// ========
	// Frame length in clocks, 96 bits of 8 clocks
	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N)
			flen <= 10'h000;
		else
			flen <= O_LINK_FRAME ? flen + 10'h001 : 10'h000;
	end

	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);

	sequence s_wait;
		!O_HREADYOUT ##1 O_HREADYOUT;
	endsequence
	// Sampled mid bit, so link sync jitter does not matter
	sequence s_pre;
		##4 O_LINK_DATA ##8 !O_LINK_DATA ##8 O_LINK_DATA ##8 !O_LINK_DATA;
	endsequence

	a_one_wait: assert property (take |=> s_wait)
		else $error("wait state missing");
	a_ready_cause: assert property ($fell(O_HREADYOUT) |-> $past(take))
		else $error("ready dropped without transfer");
	a_resp_okay: assert property (!O_HRESP)
		else $error("response not okay");
	a_rdata_holds: assert property (!$past(take && !I_HWRITE, 2) |-> $stable(O_HRDATA))
		else $error("read data moved");
	a_frame_len: assert property ($fell(O_LINK_FRAME) |-> flen >= 10'h2F8 && flen <= 10'h308)
		else $error("frame length wrong");
	a_preamble_bits: assert property ($rose(O_LINK_FRAME) |-> s_pre)
		else $error("preamble wrong");
	a_frame_gap: assert property ($fell(O_LINK_FRAME) |-> !O_LINK_FRAME [*6])
		else $error("frames too close");
	a_irq_clear: assert property (rd_stat && !I_LINK_FRAME && !O_LINK_FRAME |-> ##[1:4] !O_IRQ)
		else $error("interrupt not cleared");
	a_reset_quiet: assert property ($rose(I_ARST_N) |-> O_HREADYOUT && !O_IRQ && !O_LINK_FRAME)
		else $error("outputs busy after reset");
endmodule // engine_props

bind radio_packet_link_engine engine_props i_engine_props (
	.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
	.I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
	.O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_IRQ(O_IRQ), .I_LINK_FRAME(I_LINK_FRAME),
	.O_LINK_FRAME(O_LINK_FRAME), .O_LINK_DATA(O_LINK_DATA));

/* verif/link_peer.sv */
// Peer transceiver on the air side: link clock, frame capture, frame send, auto ack.
// Assumes engine output bits settle before the rising link edge.
`timescale 1ns/1ps
module link_peer (
	input  wire logic i_run,    // Let the link clock run
	input  wire logic i_ack_on, // Answer data frames
	input  wire logic i_frame,  // Frame from engine
	input  wire logic i_data,   // Data from engine
	output logic      o_lclk,   // Link clock, 80 ns
	output logic      o_frame,  // Frame to engine
	output logic      o_data    // Data to engine
);
	logic [95:0] sh = 96'h0;
	logic [95:0] last = 96'h0;
	int          n_got = 0;

	initial begin
		o_lclk = 1'b0;
		o_frame = 1'b0;
		o_data = 1'b0;
	end
	always #40 o_lclk = i_run ? ~o_lclk : 1'b0;

	function automatic logic [95:0] frame(input logic [39:0] a, input logic [7:0] c, input logic [31:0] p);
		logic [79:0] m;
		logic [7:0]  crc;
		m = {a, c, p};
		crc = 8'h00;
		for (int i = 79; i >= 0; i--)
			crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ m[i]) ? 8'h07 : 8'h00);
		return {8'hAA, m, crc};
	endfunction

	task automatic send(input logic [39:0] a, input logic [7:0] c, input logic [31:0] p);
		logic [95:0] f;
		f = frame(a, c, p);
		@(negedge o_lclk);
		o_frame = 1'b1;
		for (int i = 95; i >= 0; i--) begin
			o_data = f[i];
			@(negedge o_lclk);
		end
		o_frame = 1'b0;
		// Released line must not keep the last bit
		o_data = ~o_data;
	endtask

	always @(posedge o_lclk) begin
		if (i_frame)
			sh <= {sh[94:0], i_data};
	end
	// Rise first, or reset settling from unknown looks like a frame end
	always @(posedge i_frame) begin
		@(negedge i_frame);
		last = sh;
		n_got++;
		if (i_ack_on && sh[47:40] == 8'h00)
			send(sh[87:48], 8'h01, 32'h0);
	end
endmodule // link_peer

/* verif/tb_radio_packet_link_engine.sv */
// Testbench of the radio packet link engine: registers, send, ack, retry, receive.
// Assumes the link peer model and the bound property checker.
`timescale 1ns/1ps
`include "link_engine_regs.vh"
module tb_radio_packet_link_engine;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d;} row_t;
	localparam logic [39:0] TXA = 40'h1289ABCDEF;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        lrun = 1'b0;
	logic        ack_on = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] r;
	logic [31:0] hrdata;
	wire         hready;
	logic        hresp, irq, lclk, fin, din, fout, dout;
	logic [39:0] pa [3] = '{TXA, 40'h55667788C3, 40'h55667788E5};
	logic [2:0]  pn [3] = '{3'h0, 3'h3, 3'h5};
	int          n_fail = 0;
	int          checks = 0;
	int          cyc = 0;
	row_t rows [8] = '{
		'{1'b0, `REG_CONFIG, 32'h0}, '{1'b0, `REG_MASK, 32'h7}, '{1'b0, `REG_RETRY, 32'h3},
		'{1'b0, `REG_STATUS, 32'h670}, '{1'b1, 8'h3C, 32'hFFFFFFFF}, '{1'b0, 8'h3C, 32'h0},
		'{1'b1, `REG_P0_HI, 32'hA5}, '{1'b0, `REG_P0_HI, 32'hA5}};

	always #5 clk = ~clk;

	radio_packet_link_engine i_radio_packet_link_engine (
		.I_CLK(clk), .I_ARST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
		.I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
		.O_HREADYOUT(hready), .O_HRESP(hresp), .O_IRQ(irq), .I_LINK_CLK(lclk), .I_LINK_FRAME(fin),
		.I_LINK_DATA(din), .O_LINK_FRAME(fout), .O_LINK_DATA(dout));
	link_peer i_link_peer (.i_run(lrun), .i_ack_on(ack_on), .i_frame(fout), .i_data(dout),
		.o_lclk(lclk), .o_frame(fin), .o_data(din));

	// ========
	// Tasks
	task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Host pace is free; the task waits on hready as long as needed
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		ahb(1'b0, a, 32'h0);
	endtask
	task automatic rdclr(input logic [31:0] e);
		rd(`REG_STATUS);
		chk(r, e);
		chk(hresp, 1'b0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
	endtask
	task automatic got(input int n);
		wait (i_link_peer.n_got == n);
		@(posedge clk);
	endtask
	task automatic wirq;
		wait (irq === 1'b1);
		@(posedge clk);
	endtask
	task automatic test_done;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			test_done;
		end
	end

	// ========
	// Sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		lrun <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			ahb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w)
				chk(r, rows[i].d);
		end
		wr(`REG_TXA_LO, TXA[31:0]);
		wr(`REG_TXA_HI, {24'h0, TXA[39:32]});
		wr(`REG_TX_DATA, 32'hCAFE0001);
		wr(`REG_TX_DATA, 32'hCAFE0006);
		wr(`REG_CMD, 32'h1);
		// Second request pends over the first frame and must take the next word
		wr(`REG_CMD, 32'h1);
		got(1);
		chk(i_link_peer.last, i_link_peer.frame(TXA, 8'h00, 32'hCAFE0001));
		got(2);
		chk(i_link_peer.last, i_link_peer.frame(TXA, 8'h00, 32'hCAFE0006));
		wirq;
		rdclr(32'h672);
		wr(`REG_CONFIG, 32'h2);
		wr(`REG_P0_LO, TXA[31:0]);
		wr(`REG_P0_HI, {24'h0, TXA[39:32]});
		wr(`REG_MASK, 32'h2);
		ack_on <= 1'b1;
		wr(`REG_TX_DATA, 32'hCAFE0002);
		wr(`REG_CMD, 32'h1);
		got(3);
		chk(i_link_peer.last, i_link_peer.frame(TXA, 8'h00, 32'hCAFE0002));
		wirq;
		wr(`REG_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wr(`REG_MASK, 32'h2);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		rdclr(32'h672);
		// No answers: one resend, then give up with the packet kept
		ack_on <= 1'b0;
		wr(`REG_RETRY, 32'h1);
		wr(`REG_MASK, 32'h4);
		wr(`REG_TX_DATA, 32'hCAFE0003);
		wr(`REG_CMD, 32'h1);
		wait (fout === 1'b1);
		@(posedge clk);
		wr(`REG_TX_DATA, 32'hCAFE0004);
		wr(`REG_TX_DATA, 32'hCAFE0005);
		wirq;
		chk(96'(i_link_peer.n_got), 96'h5);
		rdclr(32'h574);
		wr(`REG_CMD, 32'h1);
		wirq;
		chk(96'(i_link_peer.n_got), 96'h7);
		chk(i_link_peer.last, i_link_peer.frame(TXA, 8'h00, 32'hCAFE0003));
		rdclr(32'h574);
		// Receiver role: three pipes, then one frame into a full FIFO
		wr(`REG_CONFIG, 32'h3);
		wr(`REG_SHARED, 32'h55667788);
		wr(`REG_LOW_1_4, 32'hD4C3B2A1);
		wr(`REG_LOW_5, 32'h000000E5);
		wr(`REG_MASK, 32'h1);
		for (int i = 0; i < 3; i++) begin
			i_link_peer.send(pa[i], 8'h00, 32'hBEEF0000 + 32'(i));
			got(8 + i);
			chk(i_link_peer.last[95:40], {8'hAA, pa[i], 8'h01});
		end
		chk(irq, 1'b1);
		i_link_peer.send(40'h55667788A1, 8'h00, 32'h0BAD0BAD);
		// Long enough for a wrongly sent ack frame to finish and be counted
		repeat (1000) @(posedge clk);
		chk(96'(i_link_peer.n_got), 96'hA);
		for (int i = 0; i < 3; i++) begin
			rd(`REG_STATUS);
			chk(r[6:4], pn[i]);
			rd(`REG_RX_DATA);
			chk(r, 32'hBEEF0000 + 32'(i));
		end
		rd(`REG_RX_DATA);
		chk(r, 32'h0);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`REG_STATUS);
		chk(r, 32'h670);
		test_done;
	end
endmodule // tb_radio_packet_link_engine
